/* File: logic/frame_sync_generator.sv */
// frame sync pulse source: external pin pass-through or internal generator
// ******************************
// Summary of operation
// - external mode passes selected pin when generator off
// - back channel gets pulse only when routed
// - all back channels launched on same edge
// - tick equals thirty back channel bit times
// - generator repeats continuously until disabled
// - generator runs only while enable bit set
// - bits 7:4 pick timing port, 0 port0
// - bit1 zero separate counts, else 50/50
// - 16-bit high/low counts over byte registers
// - bit2 sets level at generation start
// - rate code 110b selects 50 Mbps tick
// ******************************
`timescale 1ns/1ps
`default_nettype none

module frame_sync_generator (
  // clock and reset
  input  wire logic                                      mclk_i,
  input  wire logic                                      rstn_i,
  // register port
  input  wire logic [7:0]                                reg_addr_i,
  input  wire logic [7:0]                                reg_wdata_i,
  input  wire logic                                      reg_wr_i,
  input  wire logic                                      reg_rd_i,
  output logic      [7:0]                                reg_rdata_o,
  // per-port back channel settings
  input  wire logic [3*frame_sync_pkg::NUM_PORTS-1:0]    backchannel_rate_select_i,
  input  wire logic [frame_sync_pkg::NUM_PORTS-1:0]      backchannel_pin_route_i,
  // pins
  input  wire logic [frame_sync_pkg::NUM_PINS-1:0]       gpio_pin_i,
  // pulse outputs
  output logic                                           camera_sync_pulse_o,
  output logic      [frame_sync_pkg::NUM_PORTS-1:0]      backchannel_pin_signal_o
);
  import frame_sync_pkg::*;

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [7:0]           ctl_ff;
    logic [15:0]          high_ff;
    logic [15:0]          low_ff;
    gen_state_e           state_ff;
    logic [PRE_W-1:0]     pre_ff;
    logic [15:0]          ivl_ff;
    logic                 level_ff;
    logic [NUM_PINS-1:0]  meta_ff;
    logic [NUM_PINS-1:0]  pin_ff;
    logic                 pulse_ff;
    logic [NUM_PORTS-1:0] bc_ff;
    logic [7:0]           rdata_ff;
  } state_s;

  state_s s;
  state_s nxt_s;

  // a zero count still holds for one tick
  function automatic logic [15:0] count_m1(input logic [15:0] c);
    count_m1 = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
  endfunction

  function automatic logic [PRE_W-1:0] tick_m1(input logic [2:0] rate);
    tick_m1 = (rate == RATE_50M_CODE) ? PRE_W'(TICK_50M_CYC - 1) : PRE_W'(TICK_2M5_CYC - 1);
  endfunction

  logic [3:0]       src;
  logic [2:0]       rate;
  logic [PRE_W-1:0] tick_len;
  logic             tick;
  logic             ext_mode;
  logic             pulse_src;

  // ******************************
  // next state
  // ******************************
  always_comb begin
    nxt_s = s;
    src   = s.ctl_ff[SOURCE_MSB:SOURCE_LSB];
    // source field picks the timing port; undefined codes fall back to port 0
    rate  = (src <= SOURCE_PORT_MAX) ? backchannel_rate_select_i[3*src[1:0] +: 3] : backchannel_rate_select_i[2:0];
    // tick spans one back channel frame
    tick_len = tick_m1(rate);
    tick     = (s.state_ff == GEN_RUN) && (s.pre_ff == '0);
    ext_mode = src[3] && !s.ctl_ff[GEN_ENABLE_BIT];

    // pin synchroniser
    nxt_s.meta_ff = gpio_pin_i;
    nxt_s.pin_ff  = s.meta_ff;

    if (reg_wr_i) begin
      case (reg_addr_i)
        FRAME_PULSE_CONTROL_ADDR:    nxt_s.ctl_ff        = reg_wdata_i;
        PULSE_HIGH_COUNT_UPPER_ADDR: nxt_s.high_ff[15:8] = reg_wdata_i;
        PULSE_HIGH_COUNT_LOWER_ADDR: nxt_s.high_ff[7:0]  = reg_wdata_i;
        PULSE_LOW_COUNT_UPPER_ADDR:  nxt_s.low_ff[15:8]  = reg_wdata_i;
        PULSE_LOW_COUNT_LOWER_ADDR:  nxt_s.low_ff[7:0]   = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        FRAME_PULSE_CONTROL_ADDR:    nxt_s.rdata_ff = s.ctl_ff;
        PULSE_HIGH_COUNT_UPPER_ADDR: nxt_s.rdata_ff = s.high_ff[15:8];
        PULSE_HIGH_COUNT_LOWER_ADDR: nxt_s.rdata_ff = s.high_ff[7:0];
        PULSE_LOW_COUNT_UPPER_ADDR:  nxt_s.rdata_ff = s.low_ff[15:8];
        PULSE_LOW_COUNT_LOWER_ADDR:  nxt_s.rdata_ff = s.low_ff[7:0];
        default:                     nxt_s.rdata_ff = 8'h00;
      endcase
    end

    case (s.state_ff)
      GEN_IDLE: begin
        // start only on enable; initial level from bit 2
        if (s.ctl_ff[GEN_ENABLE_BIT]) begin
          nxt_s.state_ff = GEN_RUN;
          nxt_s.level_ff = s.ctl_ff[INIT_LEVEL_BIT];
          nxt_s.pre_ff   = tick_len;
          nxt_s.ivl_ff   = (s.ctl_ff[INIT_LEVEL_BIT] || s.ctl_ff[DUTY_STYLE_BIT]) ?
                           count_m1(s.high_ff) : count_m1(s.low_ff);
        end
      end
      GEN_RUN: begin
        // keeps running until the enable drops
        if (!s.ctl_ff[GEN_ENABLE_BIT]) begin
          nxt_s.state_ff = GEN_IDLE;
          nxt_s.level_ff = 1'b0;
        end else if (tick) begin
          nxt_s.pre_ff = tick_len;
          // toggle and reload with no gap
          if (s.ivl_ff == 16'h0000) begin
            nxt_s.level_ff = !s.level_ff;
            // 50/50 style reuses the high count for both halves
            nxt_s.ivl_ff   = (s.ctl_ff[DUTY_STYLE_BIT] || !s.level_ff) ?
                             count_m1(s.high_ff) : count_m1(s.low_ff);
          end else begin
            nxt_s.ivl_ff = s.ivl_ff - 16'h0001;
          end
        end else begin
          nxt_s.pre_ff = s.pre_ff - PRE_W'(1);
        end
      end
      default: nxt_s.state_ff = GEN_IDLE;
    endcase

    // external pin only while generator enable is clear
    if (s.state_ff == GEN_RUN) begin
      pulse_src = s.level_ff;
    end else if (ext_mode) begin
      pulse_src = s.pin_ff[src[2:0]];
    end else begin
      pulse_src = 1'b0;
    end
    nxt_s.pulse_ff = pulse_src;
    // per-port routing; one register launches every port together
    nxt_s.bc_ff = {NUM_PORTS{pulse_src}} & backchannel_pin_route_i;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '{ctl_ff: CTL_RESET, high_ff: {COUNT_RESET, COUNT_RESET}, low_ff: {COUNT_RESET, COUNT_RESET},
             state_ff: GEN_IDLE, pre_ff: '0, ivl_ff: 16'h0000, level_ff: 1'b0, meta_ff: '0,
             pin_ff: '0, pulse_ff: 1'b0, bc_ff: '0, rdata_ff: 8'h00};
    end else begin
      s <= nxt_s;
    end
  end

  assign reg_rdata_o              = s.rdata_ff;
  assign camera_sync_pulse_o      = s.pulse_ff;
  assign backchannel_pin_signal_o = s.bc_ff;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  AST_EXT_PASS: assert property (ext_mode && s.state_ff == GEN_IDLE |=>
    camera_sync_pulse_o == $past(s.pin_ff[src[2:0]])) else $error("external pin not passed");
  AST_ROUTE_GATE: assert property ((backchannel_pin_signal_o & ~$past(backchannel_pin_route_i)) == '0)
    else $error("pulse on unrouted port");
  AST_LOCKSTEP: assert property (backchannel_pin_signal_o ==
    ({NUM_PORTS{camera_sync_pulse_o}} & $past(backchannel_pin_route_i))) else $error("ports out of step");
  AST_TICK_SPACING: assert property (tick |=> !tick [*8]) else $error("ticks too close");
  AST_RUN_HOLDS: assert property (s.state_ff == GEN_RUN && s.ctl_ff[GEN_ENABLE_BIT] |=>
    s.state_ff == GEN_RUN) else $error("generator stopped while enabled");
  AST_EN_GATE: assert property (!s.ctl_ff[GEN_ENABLE_BIT] |=> s.state_ff == GEN_IDLE)
    else $error("generator ran while disabled");
  AST_TICK_RELOAD: assert property (tick && s.ctl_ff[GEN_ENABLE_BIT] |=>
    s.pre_ff == $past(tick_len)) else $error("tick reload wrong");
  AST_RATE_50M: assert property (src == 4'h0 && backchannel_rate_select_i[2:0] == RATE_50M_CODE |->
    tick_len == PRE_W'(TICK_50M_CYC - 1)) else $error("50 Mbps tick length wrong");
  AST_DUTY_5050: assert property (tick && s.ctl_ff[GEN_ENABLE_BIT] && s.ivl_ff == 16'h0000 &&
    s.ctl_ff[DUTY_STYLE_BIT] |=> s.ivl_ff == count_m1($past(s.high_ff))) else $error("50/50 reload wrong");
  AST_HIGH_UPPER: assert property (reg_wr_i && reg_addr_i == PULSE_HIGH_COUNT_UPPER_ADDR |=>
    s.high_ff[15:8] == $past(reg_wdata_i)) else $error("high count byte not stored");
  AST_START_LEVEL: assert property (s.state_ff == GEN_IDLE && s.ctl_ff[GEN_ENABLE_BIT] |=>
    s.level_ff == $past(s.ctl_ff[INIT_LEVEL_BIT])) else $error("start level wrong");
  AST_TOGGLE: assert property (tick && s.ctl_ff[GEN_ENABLE_BIT] && s.ivl_ff == 16'h0000 |=>
    s.level_ff != $past(s.level_ff)) else $error("no toggle at interval end");
  AST_HOLD: assert property (s.state_ff == GEN_RUN && s.ctl_ff[GEN_ENABLE_BIT] && !tick |=>
    $stable(s.level_ff)) else $error("level moved inside interval");
  AST_LOW_LOWER: assert property (reg_wr_i && reg_addr_i == PULSE_LOW_COUNT_LOWER_ADDR |=>
    s.low_ff[7:0] == $past(reg_wdata_i)) else $error("low count byte not stored");
  AST_READ_BACK: assert property (reg_rd_i && reg_addr_i == FRAME_PULSE_CONTROL_ADDR |=>
    reg_rdata_o == $past(s.ctl_ff)) else $error("control read back wrong");
  AST_SPLIT_RELOAD: assert property (tick && s.ctl_ff[GEN_ENABLE_BIT] && s.ivl_ff == 16'h0000 &&
    !s.ctl_ff[DUTY_STYLE_BIT] && s.level_ff |=>
    s.ivl_ff == count_m1($past(s.low_ff))) else $error("low reload wrong");
  AST_STOP_LOW: assert property (s.state_ff == GEN_RUN && !s.ctl_ff[GEN_ENABLE_BIT] |=>
    !s.level_ff) else $error("level left high after stop");
  AST_RATE_2M5: assert property (src == 4'h1 && backchannel_rate_select_i[5:3] != RATE_50M_CODE |->
    tick_len == PRE_W'(TICK_2M5_CYC - 1)) else $error("2.5 Mbps tick length wrong");

endmodule

`default_nettype wire

/* File: common/frame_sync_pkg.sv */
// constants, register map and types for the frame sync pulse generator
package frame_sync_pkg;

  // ******************************
  // register map
  // ******************************
  localparam logic [7:0] FRAME_PULSE_CONTROL_ADDR    = 8'h18;
  localparam logic [7:0] PULSE_HIGH_COUNT_UPPER_ADDR = 8'h19;
  localparam logic [7:0] PULSE_HIGH_COUNT_LOWER_ADDR = 8'h1a;
  localparam logic [7:0] PULSE_LOW_COUNT_UPPER_ADDR  = 8'h1b;
  localparam logic [7:0] PULSE_LOW_COUNT_LOWER_ADDR  = 8'h1c;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ******************************
  // control fields
  // ******************************
  localparam int unsigned GEN_ENABLE_BIT  = 0;
  localparam int unsigned DUTY_STYLE_BIT  = 1;
  localparam int unsigned INIT_LEVEL_BIT  = 2;
  localparam int unsigned SOURCE_LSB      = 4;
  localparam int unsigned SOURCE_MSB      = 7;
  localparam logic [3:0]  SOURCE_EXT_MIN  = 4'h8;
  localparam logic [3:0]  SOURCE_PORT_MAX = 4'h3;

  // ******************************
  // back channel timing
  // ******************************
  localparam logic [2:0]  RATE_50M_CODE = 3'h6;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FRAME_BITS    = 30;
  localparam int unsigned BIT_2M5_NS    = 400;
  localparam int unsigned BIT_50M_NS    = 20;
  localparam int unsigned TICK_2M5_CYC  = (FRAME_BITS * BIT_2M5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_50M_CYC  = (FRAME_BITS * BIT_50M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W         = 10;
  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned NUM_PINS      = 8;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_RUN  = 2'b10
  } gen_state_e;

endpackage

/* File: tb/fs_serializer_model.sv */
// partner model: remote serializers counting received sync edges
`timescale 1ns/1ps
`default_nettype none
module fs_serializer_model (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // back channel pins
  input  wire logic [3:0]  bc_sync_i,
  output logic      [31:0] edge_cnt_o
);
  logic [3:0] prev_ff;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_ff    <= 4'h0;
      edge_cnt_o <= 32'h0;
    end else begin
      prev_ff <= bc_sync_i;
      for (int p = 0; p < 4; p++) begin
        if (bc_sync_i[p] && !prev_ff[p]) edge_cnt_o[8*p +: 8] <= edge_cnt_o[8*p +: 8] + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/frame_sync_generator_bench.sv */
// self-checking bench for the frame sync pulse generator
`timescale 1ns/1ps
`default_nettype none
module frame_sync_generator_bench;
  import frame_sync_pkg::*;
  logic        mclk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, sync, last = 0;
  logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, gpio_pin_i = 0, d;
  logic [11:0] rate = 0;
  logic [3:0]  route = 0, bc;
  logic [31:0] edges;
  logic        rd_s = 0, rd_s2 = 0;
  logic [7:0]  rd_q[$];
  logic [16:0] len_q[$];
  int          n_mismatch = 0, compares = 0, seed = 75, run = 0;
  always #12.5 mclk_i = ~mclk_i;
  frame_sync_generator dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .backchannel_rate_select_i(rate), .backchannel_pin_route_i(route), .gpio_pin_i(gpio_pin_i),
    .camera_sync_pulse_o(sync), .backchannel_pin_signal_o(bc));
  fs_serializer_model far (.mclk_i(mclk_i), .rstn_i(rstn_i), .bc_sync_i(bc), .edge_cnt_o(edges));
  // ******************************
  // tasks
  // ******************************
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_read(input logic [7:0] e, input logic [7:0] g);
    chk("read data", {9'h0, e}, {9'h0, g});
  endtask
  task automatic chk_level(input string what, input logic e, input logic g);
    chk(what, {16'h0, e}, {16'h0, g});
  endtask
  task automatic chk_ports(input logic [3:0] e, input logic [3:0] g);
    chk("back channel", {13'h0, e}, {13'h0, g});
  endtask
  task automatic chk_interval(input logic [16:0] e, input logic [16:0] g);
    chk("interval", e, g);
  endtask
  task automatic chk_count(input string what, input logic [7:0] e, input logic [7:0] g);
    chk(what, {9'h0, e}, {9'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge mclk_i);
    reg_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    reg_rd_i = 1;
    reg_addr_i = a;
    rd_q.push_back(e);
    @(negedge mclk_i);
    reg_rd_i = 0;
  endtask
  task automatic wait_lvl(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sync !== v; i++) @(negedge mclk_i);
    if (sync !== v) begin
      n_mismatch++;
      $display("FAIL pulse wait expected %h seen %h", v, sync);
      end_of_test();
    end
  endtask
  // ******************************
  // monitor: takes notes off the queues
  // ******************************
  always @(posedge mclk_i) begin
    rd_s  <= reg_rd_i;
    rd_s2 <= rd_s;
  end
  always @(negedge mclk_i) begin
    if (rd_s2 && rd_q.size() > 0) chk_read(rd_q.pop_front(), reg_rdata_o);
    if (rstn_i) chk_ports({4{sync}} & route, bc);
    if (sync !== last) begin
      if (len_q.size() > 0) chk_interval(len_q.pop_front(), {last, run[15:0]});
      run = 1;
    end else run++;
    last = sync;
  end
  // ******************************
  // stimulus
  // ******************************
  initial begin
    rate = 12'($random(seed));
    rate[2:0] = RATE_50M_CODE;
    // port 1 stays on the slow rate
    if (rate[5:3] == RATE_50M_CODE) rate[5:3] = 3'h5;
    route = 4'($random(seed));
    route[0] = 1'b1;
    route[3] = 1'b0;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i) rstn_i = 1;
    for (int a = 8'h18; a <= 8'h1d; a++) rd(a[7:0], 8'h00);
    for (int a = 8'h18; a <= 8'h1d; a++) begin
      d = 8'($random(seed)) & 8'hfe;
      wr(a[7:0], d);
      rd(a[7:0], (a == 8'h1d) ? 8'h00 : d);
    end
    for (int k = 0; k < 8; k++) begin
      wr(FRAME_PULSE_CONTROL_ADDR, {4'h8 + 4'(k), 4'h0});
      gpio_pin_i = ~(8'h1 << k);
      repeat (5) @(negedge mclk_i);
      chk_level("external low", 1'b0, sync);
      gpio_pin_i = 8'h1 << k;
      repeat (5) @(negedge mclk_i);
      chk_level("external high", 1'b1, sync);
      gpio_pin_i = 8'h0;
      repeat (5) @(negedge mclk_i);
    end
    // host programs counts before enabling
    wr(8'h19, 8'h00);
    wr(8'h1a, 8'h01);
    wr(8'h1b, 8'h00);
    wr(8'h1c, 8'h02);
    wr(FRAME_PULSE_CONTROL_ADDR, 8'h01);
    wait_lvl(1, 80);
    @(negedge mclk_i);
    len_q = '{{1'b1, 16'd24}, {1'b0, 16'd48}, {1'b1, 16'd24}, {1'b0, 16'd48}};
    repeat (160) @(negedge mclk_i);
    wr(FRAME_PULSE_CONTROL_ADDR, 8'h00);
    repeat (4) @(negedge mclk_i);
    chk_level("stopped", 1'b0, sync);
    // port 0: eight pin pulses plus three generated highs
    chk_count("edges port 0", 8'd11, edges[7:0]);
    for (int p = 1; p < 4; p++) chk_count("edges", route[p] ? edges[7:0] : 8'h0, edges[8*p +: 8]);
    wr(8'h1a, 8'h02);
    wr(FRAME_PULSE_CONTROL_ADDR, 8'h07);
    wait_lvl(1, 4);
    wait_lvl(0, 60);
    @(negedge mclk_i);
    len_q = '{{1'b0, 16'd48}, {1'b1, 16'd48}, {1'b0, 16'd48}};
    repeat (200) @(negedge mclk_i);
    wr(FRAME_PULSE_CONTROL_ADDR, 8'h00);
    wr(8'h1a, 8'h01);
    wr(8'h1c, 8'h01);
    wr(FRAME_PULSE_CONTROL_ADDR, 8'h11);
    wait_lvl(1, 1000);
    @(negedge mclk_i);
    len_q = '{{1'b1, 16'd480}, {1'b0, 16'd480}};
    repeat (1000) @(negedge mclk_i);
    chk_count("pending notes", 8'h0, 8'(len_q.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
